// ==== core/beat_fifo.sv ====
// two-entry flop buffer holding read beats until the receiver takes them
// assumes a synchronous active-high reset on the shared clock
`timescale 1ns/1ps
module beat_fifo #(
	parameter int W = 18
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	beat_if.snk push,
	output logic out_valid_out,
	output logic [W-1:0] out_data_out,
	input wire logic out_ready_in
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic wr_ptr;
		logic rd_ptr;
		logic [1:0] cnt;
	} fifo_state_t;

	fifo_state_t st_q;
	fifo_state_t st_d;
	logic do_push;
	logic do_pop;

	assign push.ready = (st_q.cnt != sram_pkg::BEAT_FIFO_FULL);
	assign push.idle = (st_q.cnt == sram_pkg::BEAT_FIFO_CNT_RST);
	assign out_valid_out = !push.idle;
	assign out_data_out = st_q.mem[st_q.rd_ptr];
	assign do_push = push.valid && push.ready;
	assign do_pop = out_valid_out && out_ready_in;

	always_comb begin
		st_d = st_q;
		if (do_push) begin
			st_d.mem[st_q.wr_ptr] = push.data;
			st_d.wr_ptr = !st_q.wr_ptr;
		end
		if (do_pop) begin
			st_d.rd_ptr = !st_q.rd_ptr;
		end
		st_d.cnt = st_q.cnt + {1'h0, do_push} - {1'h0, do_pop};
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			st_q <= '0;
			st_q.wr_ptr <= sram_pkg::BEAT_FIFO_PTR_RST;
			st_q.rd_ptr <= sram_pkg::BEAT_FIFO_PTR_RST;
			st_q.cnt <= sram_pkg::BEAT_FIFO_CNT_RST;
		end else begin
			st_q <= st_d;
		end
	end
endmodule

// ==== core/beat_if.sv ====
// read beat stream between the burst core and its output buffer
// assumes both ends share clk_sys_in
`timescale 1ns/1ps
interface beat_if #(
	parameter int W = 18
);
	logic valid;
	logic ready;
	logic idle;
	logic [W-1:0] data;

	modport src (
		output valid,
		output data,
		input ready,
		input idle
	);
	modport snk (
		input valid,
		input data,
		output ready,
		output idle
	);
endinterface

// ==== core/sram_burst_byte_write.sv ====
// two-word burst ddr sram core: burst addressing, byte-masked writes, read beats
// assumes pins arrive asynchronously; each clk_sys_in edge stands for one
// alternating true/complementary input clock rise, true first after reset
`timescale 1ns/1ps

module sram_burst_byte_write #(
	parameter int LANES = 2,
	parameter int ADDR_W = 6
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic load_strobe_n_in,
	input wire logic read_write_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [LANES*sram_pkg::LANE_W-1:0] data_in,
	input wire logic [LANES-1:0] byte_lane_write_select_n_in,
	input wire logic single_clock_strap_in,
	input wire logic data_ready_in,
	output logic [LANES*sram_pkg::LANE_W-1:0] data_out,
	output logic data_oe_out,
	output logic cmd_ready_out,
	output logic single_clock_mode_out
);
	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int W = LANES * sram_pkg::LANE_W;
	localparam int DEPTH = 1 << ADDR_W;
	localparam int PIN_W = 2 + ADDR_W + W + LANES + 1;
	// strobe parks high so a reset never looks like a command
	localparam logic [PIN_W-1:0] PIN_RST = {sram_pkg::STROBE_N_RST, {(PIN_W-1){1'b0}}};

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [sram_pkg::SYNC_STAGES-1:0][PIN_W-1:0] pins;
		sram_pkg::clk_phase_t phase;
		logic [1:0] strap_cnt;
		logic single_mode;
		logic wr_cmd;
		logic [ADDR_W-1:0] wr_cmd_addr;
		logic wr_beat;
		logic [ADDR_W-1:0] first_beat_addr;
		logic [W-1:0] wr_data0;
		logic [LANES-1:0] wr_sel0_n;
		logic rd_cmd;
		logic rd_wait;
		logic [ADDR_W-1:0] rd_cmd_addr;
		logic rd_beat;
		logic [ADDR_W-1:0] rd_addr;
	} core_state_t;

	core_state_t st_q;
	core_state_t st_d;

	logic s_ld_n;
	logic s_rw;
	logic [ADDR_W-1:0] s_addr;
	logic [W-1:0] s_data;
	logic [LANES-1:0] s_sel_n;
	logic s_strap;
	logic [ADDR_W-1:0] second_beat_addr;
	logic [ADDR_W-1:0] rd_second_addr;
	logic cmd_take;
	logic [W-1:0] word_a;
	logic [W-1:0] word_b;

	beat_if #(.W(W)) rd_beats ();

	// ------------------------------------------------------------
	// pin synchroniser
	// ------------------------------------------------------------
	// second flop only; the first stage feeds nothing else
	assign {s_ld_n, s_rw, s_addr, s_data, s_sel_n, s_strap} =
		st_q.pins[sram_pkg::SYNC_STAGES-1];

	// ------------------------------------------------------------
	// burst addresses
	// ------------------------------------------------------------
	assign second_beat_addr = st_q.first_beat_addr ^ {{(ADDR_W-1){1'b0}}, 1'b1};
	assign rd_second_addr = st_q.rd_addr ^ {{(ADDR_W-1){1'b0}}, 1'b1};

	// ------------------------------------------------------------
	// command acceptance
	// ------------------------------------------------------------
	// reads are only taken with the buffer empty and no read in flight, so the
	// two beats of a burst always find room; costs back-to-back read rate
	assign cmd_ready_out = rd_beats.idle && !st_q.rd_cmd && !st_q.rd_beat;
	assign cmd_take = (st_q.phase == sram_pkg::PH_TRUE) && !s_ld_n &&
		(!s_rw || cmd_ready_out);
	assign single_clock_mode_out = st_q.single_mode;

	// ------------------------------------------------------------
	// read beat launch
	// ------------------------------------------------------------
	// with zero skew assumed between input and output pairs, the strap
	// changes the launching pair but not the cycle a beat leaves on
	always_comb begin
		rd_beats.valid = 1'b0;
		rd_beats.data = '0;
		if (st_q.rd_cmd && st_q.rd_wait && st_q.phase == sram_pkg::PH_COMP) begin
			rd_beats.valid = 1'b1;
			rd_beats.data = st_q.mem[st_q.rd_cmd_addr];
		end else if (st_q.rd_beat && st_q.phase == sram_pkg::PH_TRUE) begin
			rd_beats.valid = 1'b1;
			rd_beats.data = st_q.mem[rd_second_addr];
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		word_a = st_q.mem[st_q.first_beat_addr];
		word_b = st_q.mem[second_beat_addr];
		st_d.pins[0] = {load_strobe_n_in, read_write_in, addr_in, data_in,
			byte_lane_write_select_n_in, single_clock_strap_in};
		st_d.pins[1] = st_q.pins[0];
		st_d.phase = (st_q.phase == sram_pkg::PH_TRUE) ? sram_pkg::PH_COMP :
			sram_pkg::PH_TRUE;

		// strap caught once the synchroniser has settled, then frozen
		if (st_q.strap_cnt != sram_pkg::STRAP_SETTLE) begin
			st_d.strap_cnt = st_q.strap_cnt + 2'h1;
			st_d.single_mode = s_strap;
		end

		// a write command lives one full cycle, a read until its first beat
		st_d.wr_cmd = 1'b0;
		if (st_q.phase == sram_pkg::PH_TRUE) begin
			st_d.rd_beat = 1'b0;
			st_d.wr_beat = 1'b0;
		end
		if (cmd_take) begin
			st_d.wr_cmd = !s_rw;
			if (s_rw) begin
				st_d.rd_cmd = 1'b1;
				st_d.rd_cmd_addr = s_addr;
			end else begin
				st_d.wr_cmd_addr = s_addr;
			end
		end else if (st_q.phase == sram_pkg::PH_COMP) begin
			st_d.wr_cmd = st_q.wr_cmd;
		end

		// first write beat on the true rise of t+1, selects taken with it
		if (st_q.wr_cmd && st_q.phase == sram_pkg::PH_TRUE) begin
			st_d.wr_beat = 1'b1;
			st_d.first_beat_addr = st_q.wr_cmd_addr;
			st_d.wr_data0 = s_data;
			st_d.wr_sel0_n = s_sel_n;
		end

		// second beat on the complementary rise, then one merged array write
		if (st_q.wr_beat && st_q.phase == sram_pkg::PH_COMP) begin
			st_d.wr_beat = 1'b0;
			for (int l = 0; l < LANES; l++) begin
				if (!st_q.wr_sel0_n[l]) begin
					word_a[l*sram_pkg::LANE_W +: sram_pkg::LANE_W] =
						st_q.wr_data0[l*sram_pkg::LANE_W +: sram_pkg::LANE_W];
				end
				if (!s_sel_n[l]) begin
					word_b[l*sram_pkg::LANE_W +: sram_pkg::LANE_W] =
						s_data[l*sram_pkg::LANE_W +: sram_pkg::LANE_W];
				end
			end
			st_d.mem[st_q.first_beat_addr] = word_a;
			st_d.mem[second_beat_addr] = word_b;
		end

		// true rise of t+1 arms the launch on the complementary rise after it
		if (st_q.rd_cmd && st_q.phase == sram_pkg::PH_TRUE) begin
			st_d.rd_wait = 1'b1;
		end
		if (st_q.rd_cmd && st_q.rd_wait && st_q.phase == sram_pkg::PH_COMP) begin
			st_d.rd_cmd = 1'b0;
			st_d.rd_wait = 1'b0;
			st_d.rd_beat = 1'b1;
			st_d.rd_addr = st_q.rd_cmd_addr;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			st_q <= '0;
			st_q.pins <= {sram_pkg::SYNC_STAGES{PIN_RST}};
			st_q.phase <= sram_pkg::PHASE_RST;
			st_q.strap_cnt <= sram_pkg::STRAP_CNT_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// output buffer
	// ------------------------------------------------------------
	beat_fifo #(.W(W)) u_beat_fifo (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.push(rd_beats.snk),
		.out_valid_out(data_oe_out),
		.out_data_out(data_out),
		.out_ready_in(data_ready_in)
	);
endmodule

// ==== core/sram_pkg.sv ====
// constants shared by the burst sram core and its read beat buffer
// assumes one system clock; pins are synchronised inside the core
package sram_pkg;
	localparam int LANE_W = 9;
	localparam int SYNC_STAGES = 2;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;
	localparam logic STROBE_N_RST = 1'h1;
	localparam logic [1:0] STRAP_CNT_RST = 2'h0;
	localparam logic BEAT_FIFO_PTR_RST = 1'h0;
	localparam logic [1:0] BEAT_FIFO_CNT_RST = 2'h0;
	localparam logic [1:0] BEAT_FIFO_FULL = 2'h2;

	// one system cycle is one rising edge of the true or complementary input clock
	typedef enum logic {
		PH_TRUE = 1'h0,
		PH_COMP = 1'h1
	} clk_phase_t;

	localparam clk_phase_t PHASE_RST = PH_TRUE;
endpackage

// ==== tb/sram_burst_byte_write_chk.sv ====
// checker: port-level timing of the burst sram core
// assumes a bind onto sram_burst_byte_write and one clock domain
`timescale 1ns/1ps
module sram_burst_byte_write_chk #(
	parameter int LANES = 2
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic data_ready_in,
	input wire logic [LANES*sram_pkg::LANE_W-1:0] data_out,
	input wire logic data_oe_out,
	input wire logic cmd_ready_out,
	input wire logic single_clock_mode_out
);
	logic [1:0] pops_q;
	logic [2:0] up_q;
	// pops per burst; cleared while idle so each burst is judged alone
	always_ff @(posedge clk_sys_in) begin
		pops_q <= (rst_in || cmd_ready_out) ? 2'h0 : pops_q + 2'(data_oe_out && data_ready_in);
		up_q <= rst_in ? 3'h0 : up_q + 3'(up_q != 3'h7);
	end
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);
	property p_rst_oe; disable iff (1'b0) rst_in |=> !data_oe_out && data_out == '0; endproperty
	a_rst_oe: assert property (p_rst_oe) else $error("outputs live in reset");
	property p_rst_rdy; disable iff (1'b0) rst_in |=> cmd_ready_out; endproperty
	a_rst_rdy: assert property (p_rst_rdy) else $error("not ready in reset");
	property p_rst_scm; disable iff (1'b0) rst_in |=> !single_clock_mode_out; endproperty
	a_rst_scm: assert property (p_rst_scm) else $error("mode set in reset");
	property p_hold; data_oe_out && !data_ready_in |=> data_oe_out && $stable(data_out); endproperty
	a_hold: assert property (p_hold) else $error("beat lost in stall");
	property p_busy; data_oe_out |-> !cmd_ready_out; endproperty
	a_busy: assert property (p_busy) else $error("ready with beat out");
	property p_lat;
		$fell(cmd_ready_out) |-> !data_oe_out ##1 !data_oe_out ##1 !data_oe_out ##1 data_oe_out;
	endproperty
	a_lat: assert property (p_lat) else $error("read beat late");
	property p_pair; $rose(cmd_ready_out) |-> pops_q == 2'h2; endproperty
	a_pair: assert property (p_pair) else $error("burst not two beats");
	property p_strap; up_q == 3'h7 |-> $stable(single_clock_mode_out); endproperty
	a_strap: assert property (p_strap) else $error("mode changed");
	c_burst: cover property ($rose(cmd_ready_out));
	c_stall: cover property (data_oe_out && !data_ready_in);
	c_scm: cover property (single_clock_mode_out);
endmodule

bind sram_burst_byte_write sram_burst_byte_write_chk #(.LANES(LANES)) chk_i (.clk_sys_in,
	.rst_in, .data_ready_in, .data_out, .data_oe_out, .cmd_ready_out, .single_clock_mode_out);

// ==== tb/sram_burst_byte_write_tb_top.sv ====
// self-checking bench for the burst sram core
// assumes the controller model drives pins and the bench pops read beats
`timescale 1ns/1ps
module sram_burst_byte_write_tb_top;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic single_clock_strap_in = 1'b0;
	logic data_ready_in = 1'b1;
	logic clk_run = 1'b1;
	logic load_strobe_n_in, read_write_in, data_oe_out, cmd_ready_out, single_clock_mode_out;
	logic [5:0] addr_in;
	logic [17:0] data_in, data_out;
	logic [1:0] byte_lane_write_select_n_in;
	int errors = 0;
	int checked = 0;
	logic [17:0] b [2];
	typedef struct packed {logic [5:0] a; logic [17:0] d0, d1, e0, e1; logic [1:0] s0, s1;} row_t;
	row_t rows [4] = '{'{6'h04, 18'h3FFFF, 18'h15555, 18'h3FFFF, 18'h15555, 2'h0, 2'h0},
		'{6'h05, 18'h00000, 18'h2AAAA, 18'h15400, 18'h2ABFF, 2'h2, 2'h1},
		'{6'h3F, 18'h12345, 18'h0ABCD, 18'h00000, 18'h0ABCD, 2'h3, 2'h0},
		'{6'h3E, 18'h3FFFF, 18'h00000, 18'h3FFCD, 18'h00000, 2'h1, 2'h2}};
	// a stopped clock parks low
	always #2.5 clk_sys_in = ~clk_sys_in & (clk_run | clk_sys_in);
	sram_burst_byte_write dut (.clk_sys_in, .rst_in, .load_strobe_n_in, .read_write_in, .addr_in,
		.data_in, .byte_lane_write_select_n_in, .single_clock_strap_in, .data_ready_in,
		.data_out, .data_oe_out, .cmd_ready_out, .single_clock_mode_out);
	sram_ctl_model ctl (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.load_strobe_n_out(load_strobe_n_in), .rw_out(read_write_in), .addr_out(addr_in),
		.data_out(data_in), .sel_n_out(byte_lane_write_select_n_in));
	task automatic chk(input string nm, input logic [17:0] got, exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	// beats are taken between edges, so a stalled burst shows its hold time
	task automatic rd(input logic [5:0] x, input int st);
		int k;
		k = 0;
		b = '{default: 'x};
		data_ready_in = 1'b0;
		ctl.cmd(1'b1, x);
		repeat (st) ctl.tick();
		data_ready_in = 1'b1;
		for (int i = 0; i < 20 && k < 2; i++) begin
			if (data_oe_out === 1'b1) begin
				b[k] = data_out;
				k++;
			end
			ctl.tick();
		end
		ctl.tick();
	endtask
	task automatic tally_and_finish();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#20000;
		errors++;
		tally_and_finish();
	end
	initial begin
		repeat (10) ctl.tick();
		rst_in = 1'b0;
		chk("oe", data_oe_out, 18'h00000);
		chk("rdy", cmd_ready_out, 18'h00001);
		// --------------------------------
		// ordinary write then read cases
		// --------------------------------
		foreach (rows[i]) begin
			ctl.wr(rows[i].a, rows[i].d0, rows[i].d1, rows[i].s0, rows[i].s1);
			rd(rows[i].a, 0);
			chk("beat0", b[0], rows[i].e0);
			chk("beat1", b[1], rows[i].e1);
		end
		clk_run = 1'b0;
		#100;
		clk_run = 1'b1;
		ctl.tick();
		rd(6'h05, 6);
		chk("stall0", b[0], 18'h15400);
		chk("stall1", b[1], 18'h2ABFF);
		single_clock_strap_in = 1'b1;
		rst_in = 1'b1;
		repeat (3) ctl.tick();
		rst_in = 1'b0;
		repeat (4) ctl.tick();
		chk("scm", single_clock_mode_out, 18'h00001);
		rd(6'h04, 0);
		chk("clr", b[0], 18'h00000);
		tally_and_finish();
	end
endmodule

// ==== tb/sram_ctl_model.sv ====
// far-side memory controller model driving command and write pins
// assumes pins pass a 2-flop sync, so a command lands 3 edges later
`timescale 1ns/1ps
module sram_ctl_model (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	output logic load_strobe_n_out,
	output logic rw_out,
	output logic [5:0] addr_out,
	output logic [17:0] data_out,
	output logic [1:0] sel_n_out
);
	int n;
	always @(posedge clk_sys_in) n <= rst_in ? 0 : n + 1;
	initial begin
		load_strobe_n_out = 1'b1;
		rw_out = 1'b1;
		addr_out = 6'h00;
		data_out = 18'h00000;
		sel_n_out = 2'h3;
	end
	task automatic tick();
		@(posedge clk_sys_in);
		#1;
	endtask
	task automatic cmd(input logic r, input logic [5:0] a);
		tick();
		// odd count would land the strobe on a complementary edge
		if (n[0]) tick();
		load_strobe_n_out = 1'b0;
		rw_out = r;
		addr_out = a;
		tick();
		load_strobe_n_out = 1'b1;
		rw_out = ~r;
		addr_out = ~a;
	endtask
	task automatic wr(input logic [5:0] a, input logic [17:0] d0, d1, input logic [1:0] s0, s1);
		cmd(1'b0, a);
		tick();
		data_out = d0;
		sel_n_out = s0;
		tick();
		data_out = d1;
		sel_n_out = s1;
		tick();
		data_out = ~d1;
		sel_n_out = ~s1;
	endtask
endmodule
